//--- shared/ucal_pkg.sv
package ucal_pkg;
  // Wavelengths in picometres, steps in picometres, attenuation in millidB
  localparam logic [20:0] UCAL_MIN_START_PM = 21'h124f80;  // 1200000 pm
  localparam logic [20:0] UCAL_MAX_STOP_PM = 21'h192d50;   // 1650000 pm
  localparam logic [13:0] UCAL_MIN_STEP_PM = 14'h0064;     // 100 pm
  localparam logic [13:0] UCAL_MAX_STEP_PM = 14'h2710;     // 10000 pm
  localparam logic [8:0] UCAL_MIN_POINTS = 9'h00a;
  localparam logic [8:0] UCAL_MAX_POINTS = 9'h191;
  localparam logic [16:0] UCAL_MIN_ATT_MDB = 17'h00001;
  localparam logic [16:0] UCAL_MAX_ATT_MDB = 17'h1869f;
  localparam int UCAL_DEPTH = 401;
  localparam logic [15:0] UCAL_ERR_NONE = 16'h0000;
  localparam logic [15:0] UCAL_ERR_PARAM = 16'hff23;   // -221
  localparam logic [15:0] UCAL_ERR_BUSY = 16'h00c9;    // 201
  localparam logic [15:0] UCAL_ERR_NOSTART = 16'h00cb; // 203
  localparam logic [15:0] UCAL_ERR_NODATA = 16'h00cc;  // 204
  localparam logic [15:0] UCAL_ERR_RANGE = 16'hff22;   // -222, value out of range
  localparam logic UCAL_SEL_RESET = 1'b0;

  typedef enum logic [2:0] {
    UCAL_CMD_NONE = 3'h0,
    UCAL_CMD_BEGIN = 3'h1,
    UCAL_CMD_BEGIN_Q = 3'h2,
    UCAL_CMD_VALUE = 3'h3,
    UCAL_CMD_VALUE_Q = 3'h4,
    UCAL_CMD_END = 3'h5,
    UCAL_CMD_SELECT = 3'h6,
    UCAL_CMD_SELECT_Q = 3'h7
  } ucal_cmd_e;

  typedef struct packed {
    ucal_cmd_e cmd;
    logic [20:0] start_pm;
    logic [13:0] step_pm;
    logic [16:0] att_mdb;
    logic sel;
  } ucal_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] err;
    logic [20:0] start_pm;
    logic [13:0] step_pm;
    logic [8:0] count;
    logic [16:0] att_mdb;
    logic sel;
  } ucal_rsp_s;
endpackage : ucal_pkg

//--- src/ucal_mem.sv
module ucal_mem import ucal_pkg::*; #(
  parameter int DEPTH = UCAL_DEPTH,
  parameter int AW = 9
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [16:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [16:0] rdata
);
  logic [16:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ucal_mem

//--- src/ucal_ctrl.sv
// Notes on behaviour
// - Begin-entry takes first wavelength and spacing, opens an entry session.
// - Begin-entry with first wavelength below 1200nm is rejected.
// - Spacing accepted only from 0.1nm to 10nm inclusive.
// - Up to 401 points stored; start plus 9 spacings must not exceed 1650nm.
// - With factory table, invalid start parameters report -221; no session opens.
// - With user table active, begin-entry is refused with error 201.
// - Begin query returns start, spacing and stored point count.
// - Value entry stores one attenuation then advances the point.
// - Attenuation accepted only from 0.001dB to 99.999dB.
// - Value query returns next stored point and advances read position.
// - Value query past the last stored point reports error 204.
// - End-entry closes the open session.
// - End-entry without an open session reports error 203.
// - Table select: 0 picks factory table, 1 picks user table.
// - Select query returns 0 for factory, 1 for user table.
// - Questionable bit 8 set while wavelength is outside user data.
module ucal_ctrl import ucal_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire ucal_req_s req,
  input wire logic [20:0] oper_wave_pm,
  output ucal_rsp_s rsp,
  output logic ques_cond_q
);

  typedef enum logic [1:0] {
    UCAL_ST_IDLE = 2'b00,
    UCAL_ST_ENTRY = 2'b01,
    UCAL_ST_READ = 2'b11
  } ucal_st_e;

  ucal_st_e st_q;
  logic sel_q;
  logic [20:0] start_q;
  logic [13:0] step_q;
  logic [8:0] count_q;
  logic [8:0] wptr_q;
  logic [8:0] rptr_q;
  logic rd_pend_q;
  logic [15:0] err_rd_q;
  logic [16:0] rdata;
  logic [21:0] last_pm;
  logic param_ok;
  logic att_ok;
  logic mem_we;
  ucal_rsp_s rsp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  // Fewest points is the loosest span test; longer tables are not checked against 1650nm
  // One spare bit so a very high start cannot wrap below the limit
  assign last_pm = 22'(req.start_pm) + 22'(req.step_pm) * 22'(UCAL_MIN_POINTS - 9'h001);

  always_comb begin
    param_ok = (req.start_pm >= UCAL_MIN_START_PM)
      && (req.step_pm >= UCAL_MIN_STEP_PM) && (req.step_pm <= UCAL_MAX_STEP_PM)
      && (last_pm <= UCAL_MAX_STOP_PM);
  end

  assign att_ok = (req.att_mdb >= UCAL_MIN_ATT_MDB) && (req.att_mdb <= UCAL_MAX_ATT_MDB);

  assign mem_we = (req.cmd == UCAL_CMD_VALUE) && (st_q == UCAL_ST_ENTRY) && att_ok
    && (wptr_q < UCAL_MAX_POINTS);

  //////////////////////////////////////////////////////////////////////////////
  // Table storage
  ucal_mem #(.DEPTH(UCAL_DEPTH), .AW(9)) u_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(wptr_q),
    .wdata(req.att_mdb),
    .raddr(rptr_q),
    .rdata(rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Session state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= UCAL_ST_IDLE;
      start_q <= '0;
      step_q <= '0;
      count_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      unique case (req.cmd)
        UCAL_CMD_BEGIN: begin
          if (!sel_q && param_ok) begin
            st_q <= UCAL_ST_ENTRY;
            start_q <= req.start_pm;
            step_q <= req.step_pm;
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
          end
        end
        UCAL_CMD_VALUE: begin
          if (mem_we) begin
            wptr_q <= wptr_q + 9'h001;
            count_q <= wptr_q + 9'h001;
          end
        end
        UCAL_CMD_END: begin
          if (st_q == UCAL_ST_ENTRY) begin
            st_q <= UCAL_ST_READ;
          end
        end
        UCAL_CMD_BEGIN_Q: begin
          rptr_q <= '0;
        end
        UCAL_CMD_VALUE_Q: begin
          if (rptr_q < count_q) begin
            rptr_q <= rptr_q + 9'h001;
          end
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Table select
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= UCAL_SEL_RESET;
    end else if (req.cmd == UCAL_CMD_SELECT) begin
      sel_q <= req.sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answers; value reads wait one cycle for the memory register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
      rd_pend_q <= 1'b0;
      err_rd_q <= UCAL_ERR_NONE;
    end else begin
      rsp_q.valid <= 1'b0;
      rd_pend_q <= 1'b0;
      rsp_q.sel <= sel_q;
      if (rd_pend_q) begin
        rsp_q.valid <= 1'b1;
        rsp_q.err <= err_rd_q;
        rsp_q.att_mdb <= (err_rd_q == UCAL_ERR_NONE) ? rdata : 17'h00000;
      end
      unique case (req.cmd)
        UCAL_CMD_BEGIN: begin
          rsp_q.valid <= 1'b1;
          rsp_q.err <= sel_q ? UCAL_ERR_BUSY :
            (param_ok ? UCAL_ERR_NONE : UCAL_ERR_PARAM);
        end
        UCAL_CMD_BEGIN_Q: begin
          rsp_q.valid <= 1'b1;
          rsp_q.err <= UCAL_ERR_NONE;
          rsp_q.start_pm <= start_q;
          rsp_q.step_pm <= step_q;
          rsp_q.count <= count_q;
        end
        UCAL_CMD_VALUE: begin
          rsp_q.valid <= 1'b1;
          rsp_q.err <= (st_q != UCAL_ST_ENTRY || !mem_we) ? UCAL_ERR_RANGE : UCAL_ERR_NONE;
        end
        UCAL_CMD_VALUE_Q: begin
          rd_pend_q <= 1'b1;
          err_rd_q <= (rptr_q < count_q) ? UCAL_ERR_NONE : UCAL_ERR_NODATA;
        end
        UCAL_CMD_END: begin
          rsp_q.valid <= 1'b1;
          rsp_q.err <= (st_q == UCAL_ST_ENTRY) ? UCAL_ERR_NONE : UCAL_ERR_NOSTART;
        end
        UCAL_CMD_SELECT, UCAL_CMD_SELECT_Q: begin
          rsp_q.valid <= 1'b1;
          rsp_q.err <= UCAL_ERR_NONE;
        end
        default: begin
        end
      endcase
    end
  end

  assign rsp = rsp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Questionable condition: outside stored span, or no data at all
  // Long tables reach past 21 bits; widened so the span end never wraps
  logic [22:0] span_end;
  assign span_end = 23'(start_q) + 23'(step_q) * 23'(count_q - 9'h001);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ques_cond_q <= 1'b0;
    end else begin
      ques_cond_q <= (count_q == 9'h000) || (oper_wave_pm < start_q)
        || (oper_wave_pm > span_end);
    end
  end
endmodule : ucal_ctrl

//--- verification/ucal_ctrl_monitor.sv
module ucal_ctrl_monitor import ucal_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire ucal_req_s req,
  input wire logic [20:0] oper_wave_pm,
  input wire ucal_rsp_s rsp,
  input wire logic ques_cond_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Select lags a cycle, so a select just before a begin is skipped
  a_begin_answer: assert property (req.cmd == UCAL_CMD_BEGIN |=> rsp.valid)
    else $error("begin not answered");
  a_user_busy: assert property (req.cmd == UCAL_CMD_BEGIN && rsp.sel && $past(req.cmd) != UCAL_CMD_SELECT |=> rsp.err == UCAL_ERR_BUSY)
    else $error("begin with user table not refused");
  a_start_low: assert property (req.cmd == UCAL_CMD_BEGIN && !rsp.sel && $past(req.cmd) != UCAL_CMD_SELECT && req.start_pm < UCAL_MIN_START_PM |=> rsp.err == UCAL_ERR_PARAM)
    else $error("low start accepted");
  a_step_range: assert property (req.cmd == UCAL_CMD_BEGIN && !rsp.sel && $past(req.cmd) != UCAL_CMD_SELECT && (req.step_pm < UCAL_MIN_STEP_PM || req.step_pm > UCAL_MAX_STEP_PM) |=> rsp.err == UCAL_ERR_PARAM)
    else $error("bad step accepted");
  a_att_range: assert property (req.cmd == UCAL_CMD_VALUE && (req.att_mdb < UCAL_MIN_ATT_MDB || req.att_mdb > UCAL_MAX_ATT_MDB) |=> rsp.valid && rsp.err == UCAL_ERR_RANGE)
    else $error("bad value accepted");
  a_readback_lat: assert property (req.cmd == UCAL_CMD_VALUE_Q |-> ##2 rsp.valid)
    else $error("readback not answered");
  a_no_spurious: assert property (rsp.valid |-> $past(req.cmd) != UCAL_CMD_NONE || $past(req.cmd, 2) == UCAL_CMD_VALUE_Q)
    else $error("answer without request");
  a_sel_follow: assert property (req.cmd == UCAL_CMD_SELECT |-> ##2 rsp.sel == $past(req.sel, 2))
    else $error("select not applied");
  a_selq_answer: assert property (req.cmd == UCAL_CMD_SELECT_Q |=> rsp.valid && rsp.err == UCAL_ERR_NONE)
    else $error("select query not answered");
  c_busy: cover property (rsp.valid && rsp.err == UCAL_ERR_BUSY);
  c_nodata: cover property (rsp.valid && rsp.err == UCAL_ERR_NODATA);
  c_param: cover property (rsp.valid && rsp.err == UCAL_ERR_PARAM);
endmodule : ucal_ctrl_monitor
bind ucal_ctrl ucal_ctrl_monitor u_mon (.mclk(mclk), .rst(rst), .req(req),
  .oper_wave_pm(oper_wave_pm), .rsp(rsp), .ques_cond_q(ques_cond_q));

//--- verification/ucal_host.sv
module ucal_host import ucal_pkg::*; (
  input wire logic mclk,
  input wire ucal_rsp_s rsp,
  output ucal_req_s req
);
  timeunit 1ns;
  timeprecision 100ps;
  ucal_rsp_s got;
  initial req = '0;
  always @(posedge mclk) if (rsp.valid) got <= rsp;
  // Select level rides on att bit 0; idle fields inverted, never stale
  task op(input ucal_cmd_e c, input logic [20:0] s, input logic [13:0] p,
    input logic [16:0] a);
    @(negedge mclk);
    req <= {c, s, p, a, a[0]};
    @(negedge mclk);
    req <= {UCAL_CMD_NONE, ~s, ~p, ~a, ~a[0]};
    repeat (2) @(negedge mclk);
  endtask : op
  task load(input logic [20:0] s, input logic [13:0] p, input logic [20:0] stop);
    logic [20:0] w;
    logic [16:0] v;
    op(UCAL_CMD_BEGIN, s, p, 17'h0);
    w = s;
    v = 17'h00001;
    while (w <= stop) begin
      op(UCAL_CMD_VALUE, 21'h0, 14'h0, v);
      w = w + 21'(p);
      v = v + 17'h00001;
    end
  endtask : load
endmodule : ucal_host

//--- verification/user_wavelength_cal_table_entry_tb.sv
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module user_wavelength_cal_table_entry_tb import ucal_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [20:0] oper_wave_pm = 21'h0;
  ucal_req_s req;
  ucal_rsp_s rsp;
  logic ques_cond_q;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [20:0] bs [6] = '{21'h124f7f, 21'h13d620, 21'h13d620, 21'h186a00, 21'h124f80, 21'h17cdc0};
  logic [13:0] bp [6] = '{14'h03e8, 14'h0063, 14'h2711, 14'h2710, 14'h0064, 14'h2710};
  always #2.5 mclk = ~mclk;
  ucal_ctrl DUT (.mclk(mclk), .rst(rst), .req(req), .oper_wave_pm(oper_wave_pm), .rsp(rsp),
    .ques_cond_q(ques_cond_q));
  ucal_host host (.mclk(mclk), .rsp(rsp), .req(req));
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task t_params;
    for (int i = 0; i < 6; i++) begin
      host.op(UCAL_CMD_END, 21'h0, 14'h0, 17'h0);
      `CHK("end_err", (i == 0 || i < 5) ? UCAL_ERR_NOSTART : UCAL_ERR_NONE, host.got.err)
      host.op(UCAL_CMD_BEGIN, bs[i], bp[i], 17'h0);
      `CHK("begin_err", i < 4 ? UCAL_ERR_PARAM : UCAL_ERR_NONE, host.got.err)
    end
    host.op(UCAL_CMD_BEGIN, 21'h1fffff, 14'h2710, 17'h0);
    `CHK("begin_wrap", UCAL_ERR_PARAM, host.got.err)
    host.op(UCAL_CMD_END, 21'h0, 14'h0, 17'h0);
    $display("t_params done");
  endtask : t_params
  task t_select;
    host.op(UCAL_CMD_SELECT, 21'h0, 14'h0, 17'h1);
    host.op(UCAL_CMD_SELECT_Q, 21'h0, 14'h0, 17'h0);
    `CHK("sel_user", 1'b1, host.got.sel)
    host.op(UCAL_CMD_BEGIN, 21'h13d620, 14'h03e8, 17'h0);
    `CHK("busy_err", UCAL_ERR_BUSY, host.got.err)
    host.op(UCAL_CMD_SELECT, 21'h0, 14'h0, 17'h0);
    host.op(UCAL_CMD_SELECT_Q, 21'h0, 14'h0, 17'h0);
    `CHK("sel_fact", 1'b0, host.got.sel)
    $display("t_select done");
  endtask : t_select
  task t_table;
    host.load(21'h13d620, 14'h03e8, 21'h13de00);
    host.op(UCAL_CMD_VALUE, 21'h0, 14'h0, 17'h1869f);
    host.op(UCAL_CMD_VALUE, 21'h0, 14'h0, 17'h0);
    `CHK("att_low", UCAL_ERR_RANGE, host.got.err)
    host.op(UCAL_CMD_VALUE, 21'h0, 14'h0, 17'h186a0);
    `CHK("att_high", UCAL_ERR_RANGE, host.got.err)
    host.op(UCAL_CMD_END, 21'h0, 14'h0, 17'h0);
    `CHK("end_ok", UCAL_ERR_NONE, host.got.err)
    host.op(UCAL_CMD_END, 21'h0, 14'h0, 17'h0);
    `CHK("end_closed", UCAL_ERR_NOSTART, host.got.err)
    host.op(UCAL_CMD_BEGIN_Q, 21'h0, 14'h0, 17'h0);
    `CHK("start", 21'h13d620, host.got.start_pm)
    `CHK("step", 14'h03e8, host.got.step_pm)
    `CHK("count", 9'h004, host.got.count)
    for (int k = 0; k < 4; k++) begin
      host.op(UCAL_CMD_VALUE_Q, 21'h0, 14'h0, 17'h0);
      `CHK("att", k < 3 ? 17'(k + 1) : 17'h1869f, host.got.att_mdb)
    end
    host.op(UCAL_CMD_VALUE_Q, 21'h0, 14'h0, 17'h0);
    `CHK("nodata", UCAL_ERR_NODATA, host.got.err)
    $display("t_table done");
  endtask : t_table
  task t_ques;
    `CHK("ques_out", 1'b1, ques_cond_q)
    oper_wave_pm <= 21'h13da08;
    repeat (3) @(negedge mclk);
    `CHK("ques_in", 1'b0, ques_cond_q)
    $display("t_ques done");
  endtask : t_ques
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_params();
    t_select();
    t_table();
    oper_wave_pm <= 21'h155cc0;
    repeat (3) @(negedge mclk);
    t_ques();
    end_sim();
  end
endmodule : user_wavelength_cal_table_entry_tb
